// ### rtl/wrw_defs.vh
// constants shared by the windowed reset watchdog files
`ifndef WRW_DEFS_VH
`define WRW_DEFS_VH

// ==========================================================
// register map (byte addresses on the apb bus)
`define WRW_ADDR_W 12
`define WRW_CTRL_OFFSET 12'h024
`define WRW_STAT_OFFSET 12'h028

// ==========================================================
// watchdog_control fields and reset value
`define WRW_CTRL_RESET 8'h7F
`define WRW_ACT_BIT 7
`define WRW_TOP_BIT 6
`define WRW_COUNT_RESET 7'h7F
`define WRW_TRIP_COUNT 7'h40

// ==========================================================
// status register fields
`define WRW_ST_ACTIVE 0
`define WRW_ST_FROZEN 1
`define WRW_ST_RESUMING 2
`define WRW_ST_PULSING 3
`define WRW_ST_HW_OPT 4
`define WRW_ST_HALT_OPT 5
`define WRW_ST_PIN_LEVEL 6

// ==========================================================
// reset cause codes
`define WRW_CAUSE_NONE 2'h0
`define WRW_CAUSE_TIMEOUT 2'h1
`define WRW_CAUSE_FORCED 2'h2
`define WRW_CAUSE_HALT 2'h3

// ==========================================================
// timing
`define WRW_STEP_CYCLES 12288
`define WRW_WAKE_CYCLES 4096
`define WRW_CLK_PERIOD_NS 50
`define WRW_RST_PULSE_NS 500
`define WRW_RST_PULSE_CYCLES ((`WRW_RST_PULSE_NS + `WRW_CLK_PERIOD_NS - 1) / `WRW_CLK_PERIOD_NS)

`endif

// ### rtl/wrw_prescaler.v
// divider with run enable and restart, gives a one-cycle tick every DIV cycles while run is high
`timescale 1ns/1ns

module wrw_prescaler #(
    parameter DIV = 12288
) (
    input wire clk,
    input wire rst,
    input wire restart,
    input wire run,
    output wire tick
);
    localparam CW = (DIV < 2) ? 1 : $clog2(DIV);
    localparam integer LAST_I = DIV - 1;
    localparam [CW-1:0] LAST = LAST_I[CW-1:0];

    reg [CW-1:0] cnt_q;
    reg [CW-1:0] cnt_d;
    wire at_last;

    assign at_last = (cnt_q == LAST);
    assign tick = run & at_last & ~restart;

    // ==========================================================
    // counter
    always @* begin
        cnt_d = cnt_q;
        if (restart) begin
            cnt_d = {CW{1'b0}};
        end else if (run) begin
            if (at_last) begin
                cnt_d = {CW{1'b0}};
            end else begin
                cnt_d = cnt_q + {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

    // a stopped divider keeps its phase, so a freeze does not lose partial steps
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= {CW{1'b0}};
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule // wrw_prescaler

// ### rtl/wrw_watchdog.v
// windowed reset watchdog: apb register slave, step divider, trip and reset pulse
`timescale 1ns/1ns
`include "wrw_defs.vh"

// What this block does
// - count drops by one every 12288 cpu cycles, 64 usable steps
// - active and count going 40h to 3Fh starts reset, pin low about 500ns
// - refresh writes set activation and top bit; low six bits set steps
// - activation bit set only by software, cleared only by system reset
// - after reset watchdog is off unless hardware option is set; once on it stays on until reset
// - write setting activation with top bit clear forces immediate reset
// - hardware option makes watchdog always active, activation bit ignored
// - wait state has no effect on counting or resetting
// - halt with reset-on-halt option while active resets at once
// - halt without that option freezes count and blocks reset until wake
// - external wake resumes counting after 4096 clocks; reset wake leaves it off unless hardware option is set
// - at 8 MHz, FFh gives 98.304 ms and C0h gives 1.536 ms
// - control register resets to 7Fh
module wrw_watchdog #(
    parameter STEP_CYCLES = `WRW_STEP_CYCLES,
    parameter WAKE_CYCLES = `WRW_WAKE_CYCLES
) (
    input wire clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`WRW_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire hw_wdg_opt,
    input wire halt_rst_opt,
    input wire halt_exec,
    input wire ext_wake,
    input wire rst_pin_in,
    output reg rst_pin_out,
    output reg rst_pin_oe,
    output reg chip_reset_req,
    output reg [1:0] reset_cause
);
    localparam PULSE_CYCLES = `WRW_RST_PULSE_CYCLES;
    localparam PW = (PULSE_CYCLES < 2) ? 1 : $clog2(PULSE_CYCLES);
    localparam integer PULSE_LAST_I = PULSE_CYCLES - 1;
    localparam [PW-1:0] PULSE_LAST = PULSE_LAST_I[PW-1:0];

    // pulse states, one-hot
    localparam [1:0] PS_IDLE = 2'h1;
    localparam [1:0] PS_PULL = 2'h2;

    // ==========================================================
    // state
    reg act_q;
    reg [6:0] count_q;
    reg [6:0] count_d;
    reg frozen_q;
    reg resume_q;
    reg straps_taken_q;
    reg hw_opt_q;
    reg halt_opt_q;
    reg [1:0] pstate_q;
    reg [PW-1:0] pulse_cnt_q;

    wire active_eff;
    wire sel_ctrl;
    wire sel_stat;
    wire mapped;
    wire access_done;
    wire wr_ctrl;
    wire [7:0] wbyte;
    wire new_active;
    wire step_run;
    wire step_tick;
    wire wake_tick;
    wire pulsing;
    wire pulse_done;
    wire trip_timeout;
    wire trip_forced;
    wire trip_halt;
    wire trip;
    reg [1:0] trip_cause;
    wire [7:0] ctrl_view;
    wire [7:0] stat_view;

    // ==========================================================
    // option straps
    // caught on the first edge after release; an async load would sample a port
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            straps_taken_q <= 1'b0;
            hw_opt_q <= 1'b0;
            halt_opt_q <= 1'b0;
        end else if (!straps_taken_q) begin
            straps_taken_q <= 1'b1;
            hw_opt_q <= hw_wdg_opt;
            halt_opt_q <= halt_rst_opt;
        end
    end

    assign active_eff = act_q | hw_opt_q;

    // ==========================================================
    // apb decode
    assign sel_ctrl = (paddr == `WRW_CTRL_OFFSET);
    assign sel_stat = (paddr == `WRW_STAT_OFFSET);
    assign mapped = sel_ctrl | sel_stat;

    // one wait state: pready rises in the second access cycle
    assign access_done = psel & penable & pready;
    assign wr_ctrl = access_done & pwrite & sel_ctrl;
    assign wbyte = pwdata[7:0];

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & penable & ~pready;
            if (psel & penable & ~pready) begin
                pslverr <= ~mapped;
                if (pwrite | ~mapped) begin
                    prdata <= 32'h00000000;
                end else if (sel_ctrl) begin
                    prdata <= {24'h000000, ctrl_view};
                end else begin
                    prdata <= {24'h000000, stat_view};
                end
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // bit 7 shows the activation actually in force
    assign ctrl_view = {active_eff, count_q};

    assign stat_view[`WRW_ST_ACTIVE] = active_eff;
    assign stat_view[`WRW_ST_FROZEN] = frozen_q;
    assign stat_view[`WRW_ST_RESUMING] = resume_q;
    assign stat_view[`WRW_ST_PULSING] = pulsing;
    assign stat_view[`WRW_ST_HW_OPT] = hw_opt_q;
    assign stat_view[`WRW_ST_HALT_OPT] = halt_opt_q;
    assign stat_view[`WRW_ST_PIN_LEVEL] = rst_pin_in;
    assign stat_view[7] = 1'b0;

    // ==========================================================
    // activation bit
    // a written zero is simply not a set; only rst clears it
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            act_q <= 1'b0;
        end else if (wr_ctrl & wbyte[`WRW_ACT_BIT]) begin
            act_q <= 1'b1;
        end
    end

    assign new_active = active_eff | wbyte[`WRW_ACT_BIT];

    // ==========================================================
    // step divider and count
    // wait mode has no term here on purpose; the count runs straight through it
    assign step_run = ~frozen_q & ~resume_q & ~pulsing;

    wrw_prescaler #(
        .DIV(STEP_CYCLES)
    ) u_step (
        .clk(clk),
        .rst(rst),
        .restart(wr_ctrl),
        .run(step_run),
        .tick(step_tick)
    );

    always @* begin
        count_d = count_q;
        if (wr_ctrl) begin
            count_d = wbyte[6:0];
        end else if (step_tick) begin
            count_d = count_q - 7'h01;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= `WRW_COUNT_RESET;
        end else begin
            count_q <= count_d;
        end
    end

    // ==========================================================
    // halt freeze and wake delay
    // halt wins over a wake in the same cycle so the freeze is never missed
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            frozen_q <= 1'b0;
            resume_q <= 1'b0;
        end else begin
            if (halt_exec & ~halt_opt_q) begin
                frozen_q <= 1'b1;
            end else if (frozen_q & ext_wake) begin
                frozen_q <= 1'b0;
                resume_q <= 1'b1;
            end
            if (resume_q & wake_tick) begin
                resume_q <= 1'b0;
            end
        end
    end

    wrw_prescaler #(
        .DIV(WAKE_CYCLES)
    ) u_wake (
        .clk(clk),
        .rst(rst),
        .restart(~resume_q),
        .run(resume_q),
        .tick(wake_tick)
    );

    // ==========================================================
    // trip sources
    // from 7Fh the 40h-to-3Fh roll comes after 64 steps, from 40h after one
    assign trip_timeout = step_tick & active_eff & ~wr_ctrl &
                          (count_q == `WRW_TRIP_COUNT);
    assign trip_forced = wr_ctrl & new_active & ~wbyte[`WRW_TOP_BIT];
    assign trip_halt = halt_exec & halt_opt_q & active_eff;
    // a trip inside a running pulse is dropped; the chip is being reset anyway
    assign trip = (trip_timeout | trip_forced | trip_halt) & ~pulsing;

    // halt outranks a write in the same cycle; only the reported cause differs
    always @* begin
        if (trip_halt) begin
            trip_cause = `WRW_CAUSE_HALT;
        end else if (trip_forced) begin
            trip_cause = `WRW_CAUSE_FORCED;
        end else begin
            trip_cause = `WRW_CAUSE_TIMEOUT;
        end
    end

    // ==========================================================
    // reset pulse on the open-drain pin
    assign pulsing = (pstate_q == PS_PULL);
    // last cycle of the pulse, shared by the state and pin logic
    assign pulse_done = (pulse_cnt_q == {PW{1'b0}});

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pstate_q <= PS_IDLE;
            pulse_cnt_q <= {PW{1'b0}};
        end else begin
            case (pstate_q)
                PS_IDLE: begin
                    if (trip) begin
                        pstate_q <= PS_PULL;
                        pulse_cnt_q <= PULSE_LAST;
                    end
                end
                PS_PULL: begin
                    if (pulse_done) begin
                        pstate_q <= PS_IDLE;
                    end else begin
                        pulse_cnt_q <= pulse_cnt_q - {{(PW-1){1'b0}}, 1'b1};
                    end
                end
                default: begin
                    pstate_q <= PS_IDLE;
                    pulse_cnt_q <= {PW{1'b0}};
                end
            endcase
        end
    end

    // pin only ever pulls low; the board pull-up gives the high level
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rst_pin_out <= 1'b0;
            rst_pin_oe <= 1'b0;
            chip_reset_req <= 1'b0;
            reset_cause <= `WRW_CAUSE_NONE;
        end else begin
            rst_pin_out <= 1'b0;
            if (pstate_q == PS_IDLE) begin
                rst_pin_oe <= trip;
                chip_reset_req <= trip;
                if (trip) begin
                    reset_cause <= trip_cause;
                end
            end else if (pulse_done) begin
                rst_pin_oe <= 1'b0;
                chip_reset_req <= 1'b0;
            end
        end
    end
endmodule // wrw_watchdog

// ### tb/wrw_watchdog_chk.sv
// port checker for the windowed reset watchdog, bound onto its top
`timescale 1ns/1ns
`include "wrw_defs.vh"
// ==========
// checker
module wrw_watchdog_chk #(
    parameter STEP_CYCLES = 16,
    parameter WAKE_CYCLES = 8
) (
    input wire clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`WRW_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire hw_wdg_opt,
    input wire halt_rst_opt,
    input wire halt_exec,
    input wire ext_wake,
    input wire rst_pin_in,
    input wire rst_pin_out,
    input wire rst_pin_oe,
    input wire chip_reset_req,
    input wire [1:0] reset_cause
);
    localparam int TLO = STEP_CYCLES;
    localparam int THI = STEP_CYCLES + 2;
    wire ctl_done = psel && penable && pready && pwrite && paddr == `WRW_CTRL_OFFSET;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_pin_pair: assert property (rst_pin_oe == chip_reset_req)
        else $error("reset pin drive and reset request differ");
    a_pin_low: assert property (rst_pin_oe |-> !rst_pin_out)
        else $error("reset pin driven high");
    a_pulse_len: assert property ($rose(rst_pin_oe) |->
        rst_pin_oe [*8] ##1 rst_pin_oe ##1 rst_pin_oe ##1 !rst_pin_oe)
        else $error("reset pulse length wrong");
    a_cause_hold: assert property (rst_pin_oe && $past(rst_pin_oe) |->
        $stable(reset_cause) && reset_cause != `WRW_CAUSE_NONE)
        else $error("reset cause unstable in pulse");
    a_c0_trip: assert property (ctl_done && pwdata[7:0] == 8'hC0 && !rst_pin_oe |->
        ##[TLO:THI] ($rose(rst_pin_oe) && reset_cause == `WRW_CAUSE_TIMEOUT))
        else $error("shortest timeout not one step");
    a_forced_rst: assert property (ctl_done && pwdata[7:6] == 2'b10 && !rst_pin_oe |->
        ##[1:2] (rst_pin_oe && reset_cause == `WRW_CAUSE_FORCED))
        else $error("forced reset missing");
    a_halt_trip: assert property (halt_exec && halt_rst_opt && hw_wdg_opt && !rst_pin_oe |->
        ##[1:2] (rst_pin_oe && reset_cause == `WRW_CAUSE_HALT))
        else $error("halt reset missing");
    a_halt_freeze: assert property (halt_exec && !halt_rst_opt |=>
        ##1 (!$rose(rst_pin_oe)) [*8])
        else $error("reset while frozen");
endmodule // wrw_watchdog_chk

bind wrw_watchdog wrw_watchdog_chk #(.STEP_CYCLES(STEP_CYCLES), .WAKE_CYCLES(WAKE_CYCLES)) u_chk (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_wdg_opt(hw_wdg_opt), .halt_rst_opt(halt_rst_opt), .halt_exec(halt_exec),
    .ext_wake(ext_wake), .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
    .rst_pin_oe(rst_pin_oe), .chip_reset_req(chip_reset_req), .reset_cause(reset_cause));

// ### tb/wrw_watchdog_tb_top.sv
// self-checking bench for the windowed reset watchdog
`timescale 1ns/1ns
`include "wrw_defs.vh"
// ==========
// bench top
module wrw_watchdog_tb_top;
    localparam int STEP = 16;
    localparam int WAKE = 8;
    logic clk, rst, psel, penable, pwrite, hw_opt, halt_opt, halt_exec, ext_wake;
    logic pready, pslverr, rerr, pin_out, pin_oe, chip_req, pin_level, prev_oe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [1:0] cause;
    int err_count, checks_done, pulses, act, cnt, n, v;
    // open drain pin with pull-up
    assign pin_level = pin_oe ? pin_out : 1'b1;
    wrw_watchdog #(.STEP_CYCLES(STEP), .WAKE_CYCLES(WAKE)) u_dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hw_wdg_opt(hw_opt), .halt_rst_opt(halt_opt), .halt_exec(halt_exec),
        .ext_wake(ext_wake), .rst_pin_in(pin_level), .rst_pin_out(pin_out),
        .rst_pin_oe(pin_oe), .chip_reset_req(chip_req), .reset_cause(cause));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (pin_oe === 1'b1 && prev_oe !== 1'b1) pulses <= pulses + 1;
        prev_oe <= pin_oe;
    end
    // ==========
    // tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        // psel just released in this step: let an edge pass before the next setup
        if (psel === 1'b1) @(posedge clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] d);
        apb(1'b1, `WRW_CTRL_OFFSET, {24'h0, d});
        act = act | d[7];
        cnt = d[6:0];
    endtask
    task automatic rd_ctl;
        apb(1'b0, `WRW_CTRL_OFFSET, 32'h0);
        chk("control", {24'h0, act[0], cnt[6:0]}, rdata);
    endtask
    task automatic do_reset(input logic hw, input logic ho);
        rst <= 1'b1; hw_opt <= hw; halt_opt <= ho;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        pulses = 0; act = hw; cnt = 'h7F;
    endtask
    task automatic pulse_pin(input logic wake);
        if (wake) ext_wake <= 1'b1;
        else halt_exec <= 1'b1;
        @(posedge clk);
        ext_wake <= 1'b0; halt_exec <= 1'b0;
    endtask
    task automatic chk_trip(input int np, input logic [1:0] c);
        chk("pulses", np, pulses);
        chk("cause", 32'(c), 32'(cause));
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end
    // ==========
    // scenarios
    initial begin
        rst = 1'b1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; prev_oe = 0;
        hw_opt = 0; halt_opt = 0; halt_exec = 0; ext_wake = 0;
        err_count = 0; checks_done = 0; pulses = 0;
        v = $urandom(36);
        do_reset(1'b0, 1'b0);
        rd_ctl();
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped error", 32'h1, 32'(rerr));
        chk("unmapped data", 32'h0, rdata);
        apb(1'b1, `WRW_STAT_OFFSET, 32'hFF);
        chk("status write error", 32'h0, 32'(rerr));
        apb(1'b0, `WRW_STAT_OFFSET, 32'h0);
        chk("status", 32'h40, rdata);
        wr(8'h45);
        n = 6 + $urandom % 3;
        repeat (n * STEP - 3 + STEP / 2) @(posedge clk);
        cnt = cnt - n;
        rd_ctl();
        chk("pulses", 0, pulses);
        for (int i = 0; i < 4; i++) begin
            v = 8'hC2 + $urandom % 62;
            wr(v[7:0]);
            n = $urandom % 2;
            repeat (n * STEP - 3 + STEP / 2) @(posedge clk);
            cnt = cnt - n;
            rd_ctl();
        end
        wr(8'h7F);
        rd_ctl();
        chk("pulses", 0, pulses);
        wr(8'hC0);
        repeat (STEP + 14) @(posedge clk);
        chk_trip(1, `WRW_CAUSE_TIMEOUT);
        do_reset(1'b0, 1'b0);
        wr(8'h80 | ($urandom % 64));
        repeat (14) @(posedge clk);
        chk_trip(1, `WRW_CAUSE_FORCED);
        do_reset(1'b0, 1'b0);
        wr(8'hC1);
        pulse_pin(1'b0);
        repeat (6 * STEP) @(posedge clk);
        chk("pulses", 0, pulses);
        pulse_pin(1'b1);
        repeat (WAKE + 1) @(posedge clk);
        chk("pulses", 0, pulses);
        repeat (2 * STEP + 12) @(posedge clk);
        chk_trip(1, `WRW_CAUSE_TIMEOUT);
        do_reset(1'b1, 1'b1);
        rd_ctl();
        pulse_pin(1'b0);
        repeat (14) @(posedge clk);
        chk_trip(1, `WRW_CAUSE_HALT);
        tally_and_finish();
    end
endmodule // wrw_watchdog_tb_top
